// >>> include/dosseq_consts.vh
// Constants for the dual output start-up sequencer
`ifndef DOSSEQ_CONSTS_VH
`define DOSSEQ_CONSTS_VH
// Startup order select codes
`define DOSSEQ_ORDER_C2_FIRST 2'h1
`define DOSSEQ_ORDER_C1_FIRST 2'h2
`define DOSSEQ_ORDER_INDEP    2'h0
// Clock rate in kHz
`define DOSSEQ_CLK_KHZ        50000
// Oscillator period in clock cycles (twice the channel rate)
`define DOSSEQ_OSC_DIV        84
// Inter-channel start delay in microseconds
`define DOSSEQ_SEQ_DELAY_US   400
// Soft-start ramp time in microseconds
`define DOSSEQ_SS_TIME_US     2100
// Reference code at the end of the ramp
`define DOSSEQ_REF_FULL       10'h3FF
// Pulses skipped after an overcurrent pulse
`define DOSSEQ_SKIP_PULSES    3'h6
`endif

// >>> rtl/dosseq_pwm_gate.v
// Per-channel PWM pulse gate with overcurrent pulse skipping
`timescale 1ns/1ps
`default_nettype none
`include "dosseq_consts.vh"
module dosseq_pwm_gate (
  input  wire clk,
  input  wire rst,
  input  wire run,
  input  wire soft_start,
  input  wire slot,
  input  wire overcurrent,
  output reg  pulse_r
);
  reg [2:0] skip_r;
  // ============================================================
  // Pulse issue and skip count
  // Skipping only in soft start lets inductor current decay
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      skip_r  <= 3'h0;
      pulse_r <= 1'b0;
    end
    else if (!run)
    begin
      skip_r  <= 3'h0;
      pulse_r <= 1'b0;
    end
    else if (slot)
    begin
      if (skip_r != 3'h0)
      begin
        skip_r  <= skip_r - 3'h1;
        pulse_r <= 1'b0;
      end
      else
        pulse_r <= 1'b1;
    end
    else
    begin
      pulse_r <= 1'b0;
      if (pulse_r && overcurrent && soft_start)
        skip_r <= `DOSSEQ_SKIP_PULSES;
    end
  end
endmodule
`default_nettype wire

// >>> rtl/dosseq_ramp.v
// Soft-start digital reference ramp for one channel
`timescale 1ns/1ps
`default_nettype none
`include "dosseq_consts.vh"
module dosseq_ramp #(
  parameter STEP_CYC = 102,
  parameter W        = 10
)(
  input  wire         clk,
  input  wire         rst,
  input  wire         run,
  output reg  [W-1:0] ref_level_r,
  output reg          done_r
);
  reg [15:0] div_r;
  // ============================================================
  // Ramp stepping
  // Step interval sets total ramp length; reference held at top
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      div_r       <= 16'h0000;
      ref_level_r <= {W{1'b0}};
      done_r      <= 1'b0;
    end
    else if (!run)
    begin
      div_r       <= 16'h0000;
      ref_level_r <= {W{1'b0}};
      done_r      <= 1'b0;
    end
    else if (!done_r)
    begin
      if (div_r == STEP_CYC[15:0] - 16'h0001)
      begin
        div_r <= 16'h0000;
        if (ref_level_r == {W{1'b1}})
          done_r <= 1'b1;
        else
          ref_level_r <= ref_level_r + {{(W-1){1'b0}}, 1'b1};
      end
      else
        div_r <= div_r + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// >>> rtl/dosseq_top.v
// Start-up sequencer for a dual step-down converter
// What this block does
// - Below lockout keep bias, channels and switches off; oscillator still runs
// - Above lockout, enabled channel starts bias regulator
// - Bias good enables PWM and soft start
// - Oscillator runs at twice channel rate
// - Channels switch on alternating oscillator cycles
// - Active-low per-channel enable starts soft start
// - Both enables high: shutdown, bias off
// - Disable after regulation: upper switch off, pulldown off
// - Order select captured at power-on, three modes
// - Channel 2 first: channel 1 after delay
// - Channel 2 first: enable high stops both
// - Channel 2 first: channel 1 enable only keeps bias
// - Channel 1 first: channel 2 after delay
// - Channel 1 first: enable high stops both
// - Channel 1 first: channel 2 enable only keeps bias
// - Independent mode joint enable gives simultaneous ramps
// - Independent mode separate enables act independently
// - Each channel ramps reference then holds
// - Overcurrent in soft start skips six pulses
`timescale 1ns/1ps
`default_nettype none
`include "dosseq_consts.vh"
module dosseq_top #(
  parameter OSC_DIV   = `DOSSEQ_OSC_DIV,
  parameter SS_CYC    = (`DOSSEQ_SS_TIME_US * (`DOSSEQ_CLK_KHZ / 1000)),
  parameter DELAY_OSC = (`DOSSEQ_SEQ_DELAY_US * (`DOSSEQ_CLK_KHZ / 1000)
                         + `DOSSEQ_OSC_DIV - 1) / `DOSSEQ_OSC_DIV
)(
  input  wire       clk,
  input  wire       rst,
  input  wire       supply_lockout,
  input  wire       bias_good,
  input  wire       chan1_enable_n,
  input  wire       chan2_enable_n,
  input  wire [1:0] startup_order_select,
  input  wire       chan1_regulated,
  input  wire       chan2_regulated,
  input  wire       chan1_overcurrent,
  input  wire       chan2_overcurrent,
  output reg        bias_regulator_on_r,
  output reg        osc_tick_r,
  output reg        chan1_run_r,
  output reg        chan2_run_r,
  output reg        chan1_soft_start_r,
  output reg        chan2_soft_start_r,
  output wire [9:0] chan1_ref_level,
  output wire [9:0] chan2_ref_level,
  output wire       chan1_upper_switch,
  output wire       chan2_upper_switch,
  output reg        chan1_pulldown_r,
  output reg        chan2_pulldown_r,
  output reg  [1:0] order_mode_r
);
  // Sequencer states
  localparam ST_LOCK  = 3'h0;
  localparam ST_SHUT  = 3'h1;
  localparam ST_BIAS  = 3'h2;
  localparam ST_RUN   = 3'h3;
  localparam ST_STOP  = 3'h4;
  localparam SS_STEP  = SS_CYC / 1024;

  reg  [2:0]  state_r;
  reg  [2:0]  state_nxt;
  reg         mode_held_r;
  reg  [7:0]  osc_cnt_r;
  reg         phase_r;
  reg  [15:0] delay_r;
  reg         lead_done_r;
  reg         any_on_r;
  reg         en1_eff;
  reg         en2_eff;
  wire        en1;
  wire        en2;
  wire        ss1_done;
  wire        ss2_done;
  wire        pwm_ok;

  // Enables are active low; inputs already synchronous
  assign en1    = ~chan1_enable_n;
  assign en2    = ~chan2_enable_n;
  assign pwm_ok = (state_r == ST_RUN);

  // ============================================================
  // Oscillator and phase
  // divider at twice channel rate
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      osc_cnt_r  <= 8'h00;
      osc_tick_r <= 1'b0;
      phase_r    <= 1'b0;
    end
    else if (osc_cnt_r == OSC_DIV[7:0] - 8'h01)
    begin
      osc_cnt_r  <= 8'h00;
      osc_tick_r <= 1'b1;
      phase_r    <= ~phase_r;
    end
    else
    begin
      osc_cnt_r  <= osc_cnt_r + 8'h01;
      osc_tick_r <= 1'b0;
    end
  end

  // ============================================================
  // Order select capture
  // latch mode once per power-on
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      order_mode_r <= `DOSSEQ_ORDER_INDEP;
      mode_held_r  <= 1'b0;
    end
    else if (supply_lockout)
      mode_held_r <= 1'b0;
    else if (!mode_held_r && bias_good)
    begin
      order_mode_r <= startup_order_select;
      mode_held_r  <= 1'b1;
    end
  end

  // ============================================================
  // Effective channel enables per mode
  always @*
  begin
    en1_eff = 1'b0;
    en2_eff = 1'b0;
    case (order_mode_r)
      `DOSSEQ_ORDER_C2_FIRST:
      begin
        en2_eff = en2;
        en1_eff = en2 && lead_done_r;
      end
      `DOSSEQ_ORDER_C1_FIRST:
      begin
        en1_eff = en1;
        en2_eff = en1 && lead_done_r;
      end
      default:
      begin
        // each enable drives its own channel
        en1_eff = en1;
        en2_eff = en2;
      end
    endcase
  end

  // ============================================================
  // Main sequencer next state
  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_LOCK:
        if (!supply_lockout)
          state_nxt = ST_SHUT;
      ST_SHUT:
        if (supply_lockout)
          state_nxt = ST_LOCK;
        else if (en1 || en2)
          state_nxt = ST_BIAS;
      ST_BIAS:
        if (supply_lockout)
          state_nxt = ST_LOCK;
        else if (!(en1 || en2))
          state_nxt = ST_SHUT;
        // Wait for the captured order so no channel starts on a stale mode
        else if (bias_good && mode_held_r)
          state_nxt = ST_RUN;
      ST_RUN:
        if (supply_lockout)
          state_nxt = ST_LOCK;
        else if (!(en1 || en2))
          state_nxt = ST_SHUT;
        else if (!bias_good)
          state_nxt = ST_BIAS;
        else if (any_on_r &&
                 (((order_mode_r == `DOSSEQ_ORDER_C2_FIRST) && !en2) ||
                  ((order_mode_r == `DOSSEQ_ORDER_C1_FIRST) && !en1)))
          state_nxt = ST_STOP;
      ST_STOP:
        // Stay stopped until the lead enable is asserted again
        if (supply_lockout)
          state_nxt = ST_LOCK;
        else if (!(en1 || en2))
          state_nxt = ST_SHUT;
        else if ((order_mode_r == `DOSSEQ_ORDER_C2_FIRST) ? en2 : en1)
          state_nxt = ST_BIAS;
      default:
        state_nxt = ST_LOCK;
    endcase
  end

  // ============================================================
  // Sequencer state, bias control, channel run flags
  // Bias stays on in ST_STOP so a restart needs no recharge
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_r             <= ST_LOCK;
      bias_regulator_on_r <= 1'b0;
      chan1_run_r         <= 1'b0;
      chan2_run_r         <= 1'b0;
      any_on_r            <= 1'b0;
    end
    else
    begin
      state_r             <= state_nxt;
      bias_regulator_on_r <= (state_nxt == ST_BIAS) ||
                             (state_nxt == ST_RUN) ||
                             (state_nxt == ST_STOP);
      // enabled channel runs once PWM allowed
      chan1_run_r <= (state_nxt == ST_RUN) && en1_eff;
      chan2_run_r <= (state_nxt == ST_RUN) && en2_eff;
      if (state_nxt != ST_RUN)
        any_on_r <= 1'b0;
      else if (chan1_regulated || chan2_regulated)
        any_on_r <= 1'b1;
    end
  end

  // ============================================================
  // Inter-channel start delay
  // delay counted in oscillator ticks
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      delay_r     <= 16'h0000;
      lead_done_r <= 1'b0;
    end
    else if (!pwm_ok ||
             ((order_mode_r == `DOSSEQ_ORDER_C2_FIRST) &&
              !(en2 && chan2_regulated && ss2_done)) ||
             ((order_mode_r == `DOSSEQ_ORDER_C1_FIRST) &&
              !(en1 && chan1_regulated && ss1_done)))
    begin
      // Once the follower started, lead loss is handled by ST_STOP
      if (!pwm_ok)
      begin
        delay_r     <= 16'h0000;
        lead_done_r <= 1'b0;
      end
      else if (!lead_done_r)
        delay_r <= 16'h0000;
    end
    else if (!lead_done_r && osc_tick_r)
    begin
      if (delay_r == DELAY_OSC[15:0] - 16'h0001)
        lead_done_r <= 1'b1;
      else
        delay_r <= delay_r + 16'h0001;
    end
  end

  // ============================================================
  // Soft-start flags and pulldown
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      chan1_soft_start_r <= 1'b0;
      chan2_soft_start_r <= 1'b0;
      chan1_pulldown_r   <= 1'b0;
      chan2_pulldown_r   <= 1'b0;
    end
    else
    begin
      chan1_soft_start_r <= chan1_run_r && !ss1_done;
      chan2_soft_start_r <= chan2_run_r && !ss2_done;
      // pulldown never turned on by disable
      chan1_pulldown_r   <= 1'b0;
      chan2_pulldown_r   <= 1'b0;
    end
  end

  // ============================================================
  // Per-channel ramps
  // reference ramp then hold
  dosseq_ramp #(
    .STEP_CYC (SS_STEP),
    .W        (10)
  ) u_ramp1 (
    .clk         (clk),
    .rst         (rst),
    .run         (chan1_run_r),
    .ref_level_r (chan1_ref_level),
    .done_r      (ss1_done)
  );

  dosseq_ramp #(
    .STEP_CYC (SS_STEP),
    .W        (10)
  ) u_ramp2 (
    .clk         (clk),
    .rst         (rst),
    .run         (chan2_run_r),
    .ref_level_r (chan2_ref_level),
    .done_r      (ss2_done)
  );

  // ============================================================
  // Pulse gates; upper switch off when channel not running
  // skip pulses after overcurrent
  dosseq_pwm_gate u_gate1 (
    .clk         (clk),
    .rst         (rst),
    .run         (chan1_run_r),
    .soft_start  (chan1_soft_start_r),
    .slot        (osc_tick_r && !phase_r),
    .overcurrent (chan1_overcurrent),
    .pulse_r     (chan1_upper_switch)
  );

  dosseq_pwm_gate u_gate2 (
    .clk         (clk),
    .rst         (rst),
    .run         (chan2_run_r),
    .soft_start  (chan2_soft_start_r),
    .slot        (osc_tick_r && phase_r),
    .overcurrent (chan2_overcurrent),
    .pulse_r     (chan2_upper_switch)
  );
endmodule
`default_nettype wire

// >>> testbench/dosseq_monitor.sv
// Concurrent checks on the start-up sequencer ports
`timescale 1ns/1ps
`default_nettype none
`include "dosseq_consts.vh"
module dosseq_monitor #(
  parameter OSC_DIV = 84
)(
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       supply_lockout,
  input wire logic       bias_good,
  input wire logic       chan1_enable_n,
  input wire logic       chan2_enable_n,
  input wire logic       chan2_regulated,
  input wire logic       bias_regulator_on_r,
  input wire logic       osc_tick_r,
  input wire logic       chan1_run_r,
  input wire logic       chan2_run_r,
  input wire logic       chan1_soft_start_r,
  input wire logic [9:0] chan1_ref_level,
  input wire logic       chan1_upper_switch,
  input wire logic       chan2_upper_switch,
  input wire logic       chan1_pulldown_r,
  input wire logic       chan2_pulldown_r,
  input wire logic [1:0] order_mode_r
);
  logic [15:0] gap_r;
  logic        seen_r;
  wire         any_en = !chan1_enable_n || !chan2_enable_n;
  wire         mode_c2 = order_mode_r == `DOSSEQ_ORDER_C2_FIRST;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Cycles since last tick; the first tick only arms the check
  always @(posedge clk or posedge rst)
    if (rst)
    begin
      gap_r <= 16'h0000;
      seen_r <= 1'b0;
    end
    else
    begin
      gap_r <= osc_tick_r ? 16'h0000 : gap_r + 16'h0001;
      seen_r <= seen_r | osc_tick_r;
    end
  // ==========================================================
  // Sequences
  sequence s_both_high;
    (chan1_enable_n && chan2_enable_n) [*3];
  endsequence
  sequence s_lead_drop;
    mode_c2 && chan2_run_r && chan2_enable_n;
  endsequence
  // ==========================================================
  // Assertions
  AST_LOCKOUT_OFF: assert property (
    supply_lockout [*3] |-> !bias_regulator_on_r && !chan1_run_r
      && !chan2_run_r && !chan1_upper_switch && !chan2_upper_switch)
    else $error("activity during lockout");
  AST_BIAS_CAUSE: assert property (
    $rose(bias_regulator_on_r) |-> $past(any_en)
      && !$past(supply_lockout))
    else $error("bias regulator on without cause");
  AST_SHUTDOWN: assert property (
    s_both_high |-> !bias_regulator_on_r && !chan1_run_r && !chan2_run_r)
    else $error("not shut down with both enables high");
  AST_RUN_NEEDS_BIAS: assert property (
    $rose(chan1_run_r) || $rose(chan2_run_r) |-> $past(bias_good))
    else $error("channel started before bias good");
  AST_OSC_PERIOD: assert property (
    osc_tick_r && seen_r |-> gap_r == OSC_DIV - 1)
    else $error("oscillator period wrong");
  AST_PULLDOWN_OFF: assert property (
    !chan1_pulldown_r && !chan2_pulldown_r)
    else $error("pulldown switched on");
  AST_SWITCH_IDLE: assert property (
    !chan1_run_r && !$past(chan1_run_r) |-> !chan1_upper_switch)
    else $error("upper switch pulses while disabled");
  AST_C2_LEADS: assert property (
    $rose(chan1_run_r) && mode_c2 |-> chan2_run_r && chan2_regulated)
    else $error("channel 1 started before channel 2 regulated");
  AST_LEADER_STOP: assert property (
    s_lead_drop |-> ##[1:2] !chan1_run_r && !chan2_run_r)
    else $error("channels not stopped together");
  AST_RAMP_TOP: assert property (
    $fell(chan1_soft_start_r) && chan1_run_r
      |-> chan1_ref_level == 10'h3FF)
    else $error("soft start ended below full reference");
endmodule
bind dosseq_top dosseq_monitor #(.OSC_DIV(OSC_DIV)) i_mon (
  .clk, .rst, .supply_lockout, .bias_good, .chan1_enable_n,
  .chan2_enable_n, .chan2_regulated, .bias_regulator_on_r, .osc_tick_r,
  .chan1_run_r, .chan2_run_r, .chan1_soft_start_r, .chan1_ref_level,
  .chan1_upper_switch, .chan2_upper_switch, .chan1_pulldown_r,
  .chan2_pulldown_r, .order_mode_r);
`default_nettype wire

// >>> testbench/dosseq_plant.sv
// Model of the bias capacitor and the two analog output stages
`timescale 1ns/1ps
`default_nettype none
module dosseq_plant (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       slow,
  input  wire logic       bias_on,
  input  wire logic       run1,
  input  wire logic       run2,
  input  wire logic [9:0] lvl1,
  input  wire logic [9:0] lvl2,
  output var  logic       bias_good,
  output var  logic       reg1,
  output var  logic       reg2
);
  logic [5:0] chg_r;
  // Bias cap charges in few or many cycles; slow tests long waits
  always @(posedge clk or posedge rst)
    if (rst)
    begin
      chg_r <= 6'h00;
      bias_good <= 1'b0;
      reg1 <= 1'b0;
      reg2 <= 1'b0;
    end
    else
    begin
      chg_r <= !bias_on ? 6'h00 : (chg_r == 6'h3F) ? chg_r : chg_r + 6'h01;
      bias_good <= bias_on && (chg_r >= (slow ? 6'h1E : 6'h03));
      // Output only regulates once its reference is at full scale
      reg1 <= run1 && (lvl1 == 10'h3FF);
      reg2 <= run2 && (lvl2 == 10'h3FF);
    end
endmodule
`default_nettype wire

// >>> testbench/tb_dual_output_startup_sequencer.sv
// Self-checking bench for the start-up sequencer
`timescale 1ns/1ps
`default_nettype none
`include "dosseq_consts.vh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  n_errors++; $display("wrong value at %0t: %h expected %h", $time, g, e); \
  end end
`define WAITHI(s) begin k = 0; while ((s) !== 1'b1 && k < 8000) begin \
  @(posedge clk); #2; k++; end if (k >= 8000) n_errors++; end
module tb_dual_output_startup_sequencer;
  localparam int OD = 8;
  localparam int DL = 2;
  localparam int SS = 2048;
  logic clk, rst, supply_lockout, bias_good, chan1_enable_n, chan2_enable_n;
  logic chan1_regulated, chan2_regulated, chan1_overcurrent, slow, lead;
  logic chan2_overcurrent;
  logic bias_regulator_on_r, osc_tick_r, chan1_run_r, chan2_run_r;
  logic chan1_soft_start_r, chan2_soft_start_r, chan1_pulldown_r;
  logic chan2_pulldown_r, chan1_upper_switch, chan2_upper_switch;
  logic [1:0] startup_order_select, order_mode_r;
  logic [9:0] chan1_ref_level, chan2_ref_level;
  int n_errors, samples_checked, k, cyc;
  wire ldr_run = lead ? chan2_run_r : chan1_run_r;
  wire fol_run = lead ? chan1_run_r : chan2_run_r;
  wire ldr_reg = lead ? chan2_regulated : chan1_regulated;
  dosseq_top #(.OSC_DIV(OD), .SS_CYC(SS), .DELAY_OSC(DL)) i_dut (
    .clk, .rst, .supply_lockout, .bias_good, .chan1_enable_n,
    .chan2_enable_n, .startup_order_select, .chan1_regulated,
    .chan2_regulated, .chan1_overcurrent, .chan2_overcurrent,
    .bias_regulator_on_r, .osc_tick_r, .chan1_run_r, .chan2_run_r,
    .chan1_soft_start_r, .chan2_soft_start_r, .chan1_ref_level,
    .chan2_ref_level, .chan1_upper_switch, .chan2_upper_switch,
    .chan1_pulldown_r, .chan2_pulldown_r, .order_mode_r);
  dosseq_plant i_plant (.clk, .rst, .slow, .bias_on(bias_regulator_on_r),
    .run1(chan1_run_r), .run2(chan2_run_r), .lvl1(chan1_ref_level),
    .lvl2(chan2_ref_level), .bias_good, .reg1(chan1_regulated),
    .reg2(chan2_regulated));
  // Free-running clock and a ceiling against hangs
  always #10 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      n_errors++;
      print_verdict();
    end
  end
  task print_verdict;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Inputs always move a fixed 2 ns after the edge
  task step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task power(input logic [1:0] sel, input logic e1, input logic e2);
    supply_lockout = 1;
    chan1_enable_n = 1;
    chan2_enable_n = 1;
    startup_order_select = sel;
    step(4);
    supply_lockout = 0;
    step(2);
    // enables driven firmly, as through a small RC resistor
    chan1_enable_n = e1;
    chan2_enable_n = e2;
  endtask
  task t_lockout;
    chan1_enable_n = 0;
    chan2_enable_n = 0;
    step(6);
    `CHK(bias_regulator_on_r | chan1_run_r | chan2_run_r, 1'b0)
  endtask
  task t_shutdown;
    power(`DOSSEQ_ORDER_INDEP, 1, 1);
    step(6);
    `CHK(bias_regulator_on_r, 1'b0)
    chan2_enable_n = 0;
    `WAITHI(bias_regulator_on_r)
    `CHK(k <= 2, 1'b1)
    `WAITHI(chan2_run_r)
    `CHK(bias_good, 1'b1)
    chan2_enable_n = 1;
    step(4);
    `CHK(bias_regulator_on_r | chan2_run_r, 1'b0)
  endtask
  // Leader first, follower a fixed number of ticks later
  task t_order(input logic [1:0] sel);
    lead = (sel == `DOSSEQ_ORDER_C2_FIRST);
    power(sel, !lead, lead);
    step(60);
    `CHK(bias_regulator_on_r, 1'b1)
    `CHK(order_mode_r, sel)
    `CHK(ldr_run | fol_run, 1'b0)
    if (lead) chan2_enable_n = 0;
    else chan1_enable_n = 0;
    `WAITHI(ldr_run)
    `CHK(fol_run, 1'b0)
    `WAITHI(ldr_reg)
    `WAITHI(fol_run)
    `CHK(k >= (DL - 1) * OD && k <= (DL + 1) * OD + 2, 1'b1)
    if (lead) chan2_enable_n = 1;
    else chan1_enable_n = 1;
    step(3);
    `CHK(chan1_run_r | chan2_run_r, 1'b0)
    `CHK(bias_regulator_on_r, 1'b1)
  endtask
  task t_indep(input logic [1:0] sel);
    power(sel, 0, 1);
    `WAITHI(chan1_soft_start_r)
    `WAITHI(!chan1_soft_start_r)
    `CHK(k >= SS - 4 && k <= SS + 4, 1'b1)
    `CHK(chan1_ref_level, 10'h3FF)
    `CHK(chan2_run_r, 1'b0)
    chan2_enable_n = 0;
    `WAITHI(chan2_run_r)
    step(1);
    `CHK(chan2_soft_start_r, 1'b1)
    `CHK(chan1_run_r, 1'b1)
    chan1_enable_n = 1;
    chan2_enable_n = 1;
    step(8);
    chan1_enable_n = 0;
    chan2_enable_n = 0;
    `WAITHI(chan1_run_r)
    `CHK(chan2_run_r, 1'b1)
    `WAITHI(chan1_regulated)
    `CHK(chan2_regulated, 1'b1)
    `CHK(chan2_ref_level, 10'h3FF)
  endtask
  task t_osc;
    `WAITHI(chan1_upper_switch)
    step(1);
    `WAITHI(chan2_upper_switch)
    `CHK(k, OD - 1)
    step(1);
    `WAITHI(chan2_upper_switch)
    `CHK(k, 2 * OD - 1)
  endtask
  task t_skip;
    power(`DOSSEQ_ORDER_INDEP, 0, 1);
    `WAITHI(chan1_upper_switch)
    chan1_overcurrent = 1;
    step(1);
    chan1_overcurrent = 0;
    `WAITHI(chan1_upper_switch)
    `CHK(k, (`DOSSEQ_SKIP_PULSES + 1) * 2 * OD - 1)
    step(1);
    `WAITHI(chan1_upper_switch)
    `CHK(k, 2 * OD - 1)
    // Same skip on channel 2, started now so it is in soft start
    chan2_enable_n = 0;
    `WAITHI(chan2_upper_switch)
    chan2_overcurrent = 1;
    step(1);
    chan2_overcurrent = 0;
    `WAITHI(chan2_upper_switch)
    `CHK(k, (`DOSSEQ_SKIP_PULSES + 1) * 2 * OD - 1)
  endtask
  initial
  begin
    {clk, slow, lead, chan1_overcurrent, chan2_overcurrent} = '0;
    {cyc, n_errors} = '0;
    {rst, supply_lockout, chan1_enable_n, chan2_enable_n} = 4'hF;
    samples_checked = 0;
    startup_order_select = 2'h0;
    step(20);
    `CHK(bias_regulator_on_r | osc_tick_r | chan1_run_r, 1'b0)
    rst = 0;
    t_lockout;
    t_shutdown;
    t_order(`DOSSEQ_ORDER_C2_FIRST);
    slow = 1;
    t_order(`DOSSEQ_ORDER_C1_FIRST);
    slow = 0;
    t_indep(`DOSSEQ_ORDER_INDEP);
    t_indep(2'h3);
    t_osc;
    t_skip;
    rst = 1;
    supply_lockout = 1;
    step(1);
    `CHK(chan1_run_r | bias_regulator_on_r, 1'b0)
    print_verdict;
  end
endmodule
`default_nettype wire
